// ===== hw/vtc_top.sv
// control and status register for the fixed voltage reference and temperature indicator
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module vtc_top #(
    parameter bit LOW_VOLTAGE_VARIANT = 1'b1,
    parameter int SETTLE_US = vtc_pkg::SETTLE_US_DEFAULT,
    parameter int TEMP_WAIT_US = vtc_pkg::TEMP_WAIT_US
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [vtc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [vtc_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [vtc_pkg::DATA_W-1:0] rdata_out,
    input wire logic adc_temp_select_in,
    input wire logic adc_conv_start_in,
    output logic vref_enable_out,
    output logic vref_ready_out,
    output logic temp_indicator_enable_out,
    output logic temp_range_select_out,
    output vtc_pkg::vtc_gain_e comparator_ref_gain_out,
    output vtc_pkg::vtc_gain_e adc_ref_gain_out,
    output logic temp_chan_route_out,
    output logic temp_acq_ready_out,
    output logic irq_out
);
    generate
        if (SETTLE_US < 1 || TEMP_WAIT_US < 1) begin : g_bad_time
            $error("vtc_top needs settle and wait times of at least 1 us");
        end
    endgenerate

    localparam int DIV_W = $clog2(vtc_pkg::US_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(vtc_pkg::US_CYCLES - 1);

    // microsecond tick divider
    logic [DIV_W-1:0] div_reg, div_next;
    logic tick;

    always_comb begin
        div_next = div_reg + DIV_W'(1);
        if (div_reg == DIV_LAST) begin
            div_next = '0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick = (div_reg == DIV_LAST);

    // bus decode
    logic wr_ctrl, wr_mask, rd_status;
    assign wr_ctrl = wr_in && (addr_in == vtc_pkg::CTRL_ADDR);
    assign wr_mask = wr_in && (addr_in == vtc_pkg::MASK_ADDR);
    assign rd_status = rd_in && (addr_in == vtc_pkg::STATUS_ADDR);

    // control register; the ready position of the write data is dropped here
    vtc_pkg::vtc_ctrl_s ctrl_reg, ctrl_next;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next.vref_enable = wdata_in[vtc_pkg::BIT_VREF_EN];
            ctrl_next.temp_indicator_enable = wdata_in[vtc_pkg::BIT_TEMP_EN];
            ctrl_next.temp_range_select = wdata_in[vtc_pkg::BIT_TEMP_RNG];
            ctrl_next.comparator_ref_gain =
                vtc_pkg::vtc_gain_e'(wdata_in[vtc_pkg::CMP_GAIN_HI:vtc_pkg::CMP_GAIN_LO]);
            ctrl_next.adc_ref_gain =
                vtc_pkg::vtc_gain_e'(wdata_in[vtc_pkg::ADC_GAIN_HI:vtc_pkg::ADC_GAIN_LO]);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl_reg <= vtc_pkg::CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // settling timer restarts whenever the reference is off
    logic settle_done;
    vtc_us_timer #(
        .LIMIT_US(SETTLE_US)
    ) u_settle (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .restart_in(1'b0),
        .run_in(ctrl_reg.vref_enable),
        .done_out(settle_done),
        .done_pulse_out()
    );

    // standard-voltage parts have no usable settling status, so ready is tied high
    logic ready;
    assign ready = LOW_VOLTAGE_VARIANT ? (ctrl_reg.vref_enable && settle_done) : 1'b1;

    logic ready_prev_reg, ready_prev_next;
    logic temp_sel_prev_reg, temp_sel_prev_next;

    always_comb begin
        ready_prev_next = ready;
        temp_sel_prev_next = adc_temp_select_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            // standard parts hold ready high, so start from that level to avoid a false rise event
            ready_prev_reg <= ~LOW_VOLTAGE_VARIANT;
            temp_sel_prev_reg <= 1'b0;
        end else begin
            ready_prev_reg <= ready_prev_next;
            temp_sel_prev_reg <= temp_sel_prev_next;
        end
    end

    // acquisition wait restarts on channel switch and on every conversion of the channel
    logic temp_restart, temp_conv, acq_done, acq_done_pulse;
    assign temp_conv = adc_conv_start_in && adc_temp_select_in;
    assign temp_restart = (adc_temp_select_in && !temp_sel_prev_reg) || temp_conv;

    vtc_us_timer #(
        .LIMIT_US(TEMP_WAIT_US)
    ) u_temp_wait (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .restart_in(temp_restart),
        .run_in(adc_temp_select_in && ctrl_reg.temp_indicator_enable),
        .done_out(acq_done),
        .done_pulse_out(acq_done_pulse)
    );

    // sticky events; a set in the clearing cycle survives the read
    logic [vtc_pkg::EV_W-1:0] status_reg, status_next;
    logic [vtc_pkg::EV_W-1:0] mask_reg, mask_next;
    logic [vtc_pkg::EV_W-1:0] ev_set;

    always_comb begin
        ev_set = vtc_pkg::EV_NONE;
        ev_set[vtc_pkg::EV_READY_ROSE] = ready && !ready_prev_reg;
        ev_set[vtc_pkg::EV_TEMP_WAIT_DONE] = acq_done_pulse;
        ev_set[vtc_pkg::EV_TEMP_EARLY] = temp_conv && !acq_done;
        status_next = rd_status ? (ev_set) : (status_reg | ev_set);
        mask_next = wr_mask ? wdata_in[vtc_pkg::EV_W-1:0] : mask_reg;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            status_reg <= vtc_pkg::EV_NONE;
            mask_reg <= vtc_pkg::EV_NONE;
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_next;
        end
    end

    // read data stand for exactly one cycle, zero otherwise
    logic [vtc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
    logic [vtc_pkg::DATA_W-1:0] ctrl_view;

    always_comb begin
        ctrl_view = vtc_pkg::RD_ZERO;
        ctrl_view[vtc_pkg::BIT_VREF_EN] = ctrl_reg.vref_enable;
        ctrl_view[vtc_pkg::BIT_READY] = ready;
        ctrl_view[vtc_pkg::BIT_TEMP_EN] = ctrl_reg.temp_indicator_enable;
        ctrl_view[vtc_pkg::BIT_TEMP_RNG] = ctrl_reg.temp_range_select;
        ctrl_view[vtc_pkg::CMP_GAIN_HI:vtc_pkg::CMP_GAIN_LO] = ctrl_reg.comparator_ref_gain;
        ctrl_view[vtc_pkg::ADC_GAIN_HI:vtc_pkg::ADC_GAIN_LO] = ctrl_reg.adc_ref_gain;
        rdata_next = vtc_pkg::RD_ZERO;
        if (rd_in) begin
            case (addr_in)
                vtc_pkg::CTRL_ADDR: rdata_next = ctrl_view;
                vtc_pkg::STATUS_ADDR: rdata_next[vtc_pkg::EV_W-1:0] = status_reg;
                vtc_pkg::MASK_ADDR: rdata_next[vtc_pkg::EV_W-1:0] = mask_reg;
                default: rdata_next = vtc_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_reg <= vtc_pkg::RD_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // outputs to the analog side, the register bus and the interrupt line
    assign rdata_out = rdata_reg;
    assign vref_enable_out = ctrl_reg.vref_enable;
    assign vref_ready_out = ready;
    assign temp_indicator_enable_out = ctrl_reg.temp_indicator_enable;
    assign temp_range_select_out = ctrl_reg.temp_range_select;
    assign comparator_ref_gain_out = ctrl_reg.comparator_ref_gain;
    assign adc_ref_gain_out = ctrl_reg.adc_ref_gain;
    assign temp_chan_route_out = ctrl_reg.temp_indicator_enable && adc_temp_select_in;
    assign temp_acq_ready_out = acq_done;
    assign irq_out = |(status_reg & mask_reg);

    // checks
    property p_vref_en_write;
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_ctrl |=> (vref_enable_out == $past(wdata_in[vtc_pkg::BIT_VREF_EN]));
    endproperty
    a_vref_en_write: assert property (p_vref_en_write) else $error("reference enable did not follow write");

    property p_ready_needs_enable;
        @(posedge sys_clk_in) disable iff (rst_in)
        (LOW_VOLTAGE_VARIANT && !vref_enable_out) |-> !vref_ready_out;
    endproperty
    a_ready_needs_enable: assert property (p_ready_needs_enable) else $error("ready high while disabled");

    property p_ready_standard;
        @(posedge sys_clk_in) disable iff (rst_in)
        !LOW_VOLTAGE_VARIANT |-> (vref_ready_out && rd_in && addr_in == vtc_pkg::CTRL_ADDR
            ##1 rdata_out[vtc_pkg::BIT_READY]) or !(rd_in && addr_in == vtc_pkg::CTRL_ADDR);
    endproperty
    a_ready_standard: assert property (p_ready_standard) else $error("standard variant ready not 1");

    property p_temp_fields;
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_ctrl |=> (temp_indicator_enable_out == $past(wdata_in[vtc_pkg::BIT_TEMP_EN]))
            && (temp_range_select_out == $past(wdata_in[vtc_pkg::BIT_TEMP_RNG]));
    endproperty
    a_temp_fields: assert property (p_temp_fields) else $error("temperature fields did not follow write");

    property p_range_hold;
        @(posedge sys_clk_in) disable iff (rst_in)
        !wr_ctrl |=> $stable(temp_range_select_out);
    endproperty
    a_range_hold: assert property (p_range_hold) else $error("range changed without a write");

    property p_cmp_gain;
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_ctrl |=> (comparator_ref_gain_out == $past(wdata_in[vtc_pkg::CMP_GAIN_HI:vtc_pkg::CMP_GAIN_LO]));
    endproperty
    a_cmp_gain: assert property (p_cmp_gain) else $error("comparator gain wrong");

    property p_adc_gain;
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_ctrl |=> (adc_ref_gain_out == $past(wdata_in[vtc_pkg::ADC_GAIN_HI:vtc_pkg::ADC_GAIN_LO]));
    endproperty
    a_adc_gain: assert property (p_adc_gain) else $error("ADC gain wrong");

    property p_reset_clear;
        @(posedge sys_clk_in)
        rst_in |=> !vref_enable_out && !temp_indicator_enable_out && !temp_range_select_out
            && comparator_ref_gain_out == vtc_pkg::VTC_GAIN_OFF && adc_ref_gain_out == vtc_pkg::VTC_GAIN_OFF;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("control not cleared by reset");

    property p_route;
        @(posedge sys_clk_in) disable iff (rst_in)
        temp_chan_route_out == (temp_indicator_enable_out && adc_temp_select_in);
    endproperty
    a_route: assert property (p_route) else $error("indicator channel routing wrong");

    property p_early_flag;
        @(posedge sys_clk_in) disable iff (rst_in)
        (temp_conv && !temp_acq_ready_out) |=> status_reg[vtc_pkg::EV_TEMP_EARLY];
    endproperty
    a_early_flag: assert property (p_early_flag) else $error("early conversion not flagged");

    property p_settle_low;
        @(posedge sys_clk_in) disable iff (rst_in)
        (LOW_VOLTAGE_VARIANT && $rose(vref_enable_out)) |-> !vref_ready_out [*8];
    endproperty
    a_settle_low: assert property (p_settle_low) else $error("ready rose before settling");

    property p_ready_write_ignored;
        @(posedge sys_clk_in) disable iff (rst_in)
        (LOW_VOLTAGE_VARIANT && wr_ctrl && wdata_in[vtc_pkg::BIT_READY] && !vref_enable_out)
            |=> !vref_ready_out;
    endproperty
    a_ready_write_ignored: assert property (p_ready_write_ignored) else $error("ready bit was writable");

    property p_ready_needs_settle;
        @(posedge sys_clk_in) disable iff (rst_in)
        (LOW_VOLTAGE_VARIANT && $rose(vref_ready_out)) |-> $past(vref_enable_out) && $past(vref_enable_out, 8);
    endproperty
    a_ready_needs_settle: assert property (p_ready_needs_settle) else $error("ready rose without settling");

    property p_acq_needs_route;
        @(posedge sys_clk_in) disable iff (rst_in)
        !temp_chan_route_out |=> !temp_acq_ready_out;
    endproperty
    a_acq_needs_route: assert property (p_acq_needs_route) else $error("acq ready off channel");

    property p_acq_min_wait;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(temp_chan_route_out) |-> !temp_acq_ready_out [*8];
    endproperty
    a_acq_min_wait: assert property (p_acq_min_wait) else $error("acquisition wait too short");

    property p_conv_restarts;
        @(posedge sys_clk_in) disable iff (rst_in)
        temp_conv |=> !temp_acq_ready_out [*8];
    endproperty
    a_conv_restarts: assert property (p_conv_restarts) else $error("conversion did not restart wait");

endmodule // vtc_top

// ===== hw/vtc_pkg.sv
// package for the fixed voltage reference and temperature indicator control block
// Behaviour
// - control bit 7 switches the fixed voltage reference on when 1 and off when 0.
// - control bit 6 reads 1 only while the reference output is usable, 0 when unsettled or disabled.
// - on the standard-voltage variant the ready bit always reads 1.
// - control bit 5 enables the temperature indicator when set and disables it when cleared.
// - control bit 4 picks the indicator range, 1 for the high range and 0 for the low range.
// - control bits 3:2 set the comparator reference gain: 00 off, 01 1x, 10 2x, 11 4x.
// - control bits 1:0 set the ADC reference gain with the same coding.
// - every writable control bit clears to 0 on any reset.
// - the indicator output is routed to its own dedicated ADC input channel.
// - after enabling, the ready bit stays low until the reference circuits have settled.
package vtc_pkg;

    // register bus geometry
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 2'h0;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 2'h1;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 2'h2;

    // control register field positions
    localparam int BIT_VREF_EN = 7;
    localparam int BIT_READY = 6;
    localparam int BIT_TEMP_EN = 5;
    localparam int BIT_TEMP_RNG = 4;
    localparam int CMP_GAIN_HI = 3;
    localparam int CMP_GAIN_LO = 2;
    localparam int ADC_GAIN_HI = 1;
    localparam int ADC_GAIN_LO = 0;

    // event status and mask field positions
    localparam int EV_READY_ROSE = 0;
    localparam int EV_TEMP_WAIT_DONE = 1;
    localparam int EV_TEMP_EARLY = 2;
    localparam int EV_W = 3;

    // reset values
    localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;
    localparam logic [EV_W-1:0] EV_NONE = 3'h0;

    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int US_CYCLES = CLK_HZ / 1_000_000;
    localparam int TEMP_WAIT_US = 200;
    localparam int TEMP_WAIT_CYCLES = TEMP_WAIT_US * US_CYCLES;
    localparam int SETTLE_US_DEFAULT = 25;

    // reference gain coding
    typedef enum logic [1:0] {
        VTC_GAIN_OFF = 2'b00,
        VTC_GAIN_1X = 2'b01,
        VTC_GAIN_2X = 2'b10,
        VTC_GAIN_4X = 2'b11
    } vtc_gain_e;

    // writable control fields
    typedef struct packed {
        logic vref_enable;
        logic temp_indicator_enable;
        logic temp_range_select;
        vtc_gain_e comparator_ref_gain;
        vtc_gain_e adc_ref_gain;
    } vtc_ctrl_s;

    localparam vtc_ctrl_s CTRL_RESET = '{1'b0, 1'b0, 1'b0, VTC_GAIN_OFF, VTC_GAIN_OFF};

endpackage

// ===== hw/vtc_us_timer.sv
// microsecond interval timer driven by a shared one-cycle tick
`timescale 1ns/1ps
module vtc_us_timer #(
    parameter int LIMIT_US = 200
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire logic restart_in,
    input wire logic run_in,
    output logic done_out,
    output logic done_pulse_out
);
    localparam int CW = $clog2(LIMIT_US + 2);
    // one extra tick because the first tick after restart may come early
    localparam logic [CW-1:0] LAST = CW'(LIMIT_US);

    generate
        if (LIMIT_US < 1) begin : g_bad_limit
            $error("vtc_us_timer needs LIMIT_US of at least 1");
        end
    endgenerate

    logic [CW-1:0] count_reg, count_next;
    logic done_reg, done_next;
    logic pulse_reg, pulse_next;

    // count ticks until the limit, then hold done until restarted or run_in drops
    always_comb begin
        count_next = count_reg;
        done_next = done_reg;
        pulse_next = 1'b0;
        if (restart_in || !run_in) begin
            count_next = '0;
            done_next = 1'b0;
        end else if (tick_in && !done_reg) begin
            if (count_reg == LAST) begin
                done_next = 1'b1;
                pulse_next = 1'b1;
            end else begin
                count_next = count_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            count_reg <= '0;
            done_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg <= done_next;
            pulse_reg <= pulse_next;
        end
    end

    assign done_out = done_reg;
    assign done_pulse_out = pulse_reg;
endmodule // vtc_us_timer

// ===== sim/vtc_top_test.sv
// self-checking testbench for the voltage reference and temperature indicator control block
`timescale 1ns/1ps
module vtc_top_test;
    localparam int SETTLE = 2;
    localparam int WAITUS = 3;
    localparam int USC = vtc_pkg::US_CYCLES;

    logic sys_clk_in;
    logic rst_in;
    logic [1:0] addr_in;
    logic [7:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [7:0] rdata_out;
    logic sel;
    logic conv;
    logic vref_en;
    logic ready;
    logic ready_std;
    logic ten;
    logic trng;
    vtc_pkg::vtc_gain_e cg;
    vtc_pkg::vtc_gain_e ag;
    logic route;
    logic acq;
    logic irq;
    logic [7:0] d;
    int num_errors = 0;
    int checked = 0;
    int n;
    // table rows: control write and the readback it should give (bit 6 never sticks)
    logic [7:0] row_wd [8] = '{8'h40, 8'h05, 8'h0A, 8'h0F, 8'h30, 8'h20, 8'h10, 8'h74};
    logic [7:0] row_rb [8] = '{8'h00, 8'h05, 8'h0A, 8'h0F, 8'h30, 8'h20, 8'h10, 8'h34};

    vtc_top #(.LOW_VOLTAGE_VARIANT(1'b1), .SETTLE_US(SETTLE), .TEMP_WAIT_US(WAITUS)) dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .adc_temp_select_in(sel),
        .adc_conv_start_in(conv), .vref_enable_out(vref_en), .vref_ready_out(ready),
        .temp_indicator_enable_out(ten), .temp_range_select_out(trng), .comparator_ref_gain_out(cg),
        .adc_ref_gain_out(ag), .temp_chan_route_out(route), .temp_acq_ready_out(acq), .irq_out(irq));

    // standard variant shares every input; only its ready output is looked at
    vtc_top #(.LOW_VOLTAGE_VARIANT(1'b0), .SETTLE_US(SETTLE), .TEMP_WAIT_US(WAITUS)) dut_std (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(), .adc_temp_select_in(sel),
        .adc_conv_start_in(conv), .vref_enable_out(), .vref_ready_out(ready_std),
        .temp_indicator_enable_out(), .temp_range_select_out(), .comparator_ref_gain_out(),
        .adc_ref_gain_out(), .temp_chan_route_out(), .temp_acq_ready_out(), .irq_out());

    // 50 ns clock
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task automatic conclude();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t register value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t output bit %b expected %b", $time, got, exp);
        end
    endtask

    // one-cycle write strobe launched at an edge; returns 1 ns after the edge that took it
    task automatic bus_wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so take them inside that cycle
    task automatic bus_rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1;
        v = rdata_out;
    endtask

    // one-cycle conversion start pulse launched at an edge
    task automatic conv_pulse();
        @(posedge sys_clk_in);
        conv <= 1'b1;
        @(posedge sys_clk_in);
        conv <= 1'b0;
        #1;
    endtask

    initial begin
        rst_in <= 1'b1;
        addr_in <= 2'h0;
        wdata_in <= 8'h00;
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        sel <= 1'b0;
        conv <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        #1;
        // reset values
        chk_bit(vref_en, 1'b0);
        chk_bit(ready, 1'b0);
        chk_bit(ready_std, 1'b1);
        bus_rd(vtc_pkg::CTRL_ADDR, d);
        chk_reg(d, 8'h00);
        // table of field writes, every gain code on both selects
        for (int i = 0; i < 8; i++) begin
            bus_wr(vtc_pkg::CTRL_ADDR, row_wd[i]);
            bus_rd(vtc_pkg::CTRL_ADDR, d);
            chk_reg(d, row_rb[i]);
            chk_bit(ten, row_rb[i][5]);
            chk_bit(trng, row_rb[i][4]);
            chk_reg({6'h00, cg}, {6'h00, row_rb[i][3:2]});
            chk_reg({6'h00, ag}, {6'h00, row_rb[i][1:0]});
            chk_bit(vref_en, 1'b0);
        end
        // unmapped place and read-only status ignore writes
        bus_wr(2'h3, 8'hFF);
        bus_rd(2'h3, d);
        chk_reg(d, 8'h00);
        bus_wr(vtc_pkg::STATUS_ADDR, 8'hFF);
        bus_rd(vtc_pkg::STATUS_ADDR, d);
        chk_reg(d, 8'h00);
        // enable and time the settling
        bus_wr(vtc_pkg::CTRL_ADDR, 8'h80);
        chk_bit(vref_en, 1'b1);
        chk_bit(ready, 1'b0);
        chk_bit(ready_std, 1'b1);
        n = 0;
        while (ready !== 1'b1) begin
            if (n > 200) begin
                num_errors++;
                conclude();
            end
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        chk_bit(n >= SETTLE * USC && n <= (SETTLE + 1) * USC + 2, 1'b1);
        bus_rd(vtc_pkg::CTRL_ADDR, d);
        chk_reg(d, 8'hC0);
        // ready event is held in status but masked until the mask is written
        chk_bit(irq, 1'b0);
        bus_wr(vtc_pkg::MASK_ADDR, 8'h07);
        chk_bit(irq, 1'b1);
        bus_rd(vtc_pkg::MASK_ADDR, d);
        chk_reg(d, 8'h07);
        bus_rd(vtc_pkg::STATUS_ADDR, d);
        chk_reg(d, 8'h01);
        chk_bit(irq, 1'b0);
        bus_rd(vtc_pkg::STATUS_ADDR, d);
        chk_reg(d, 8'h00);
        // disabling drops the ready flag at once
        bus_wr(vtc_pkg::CTRL_ADDR, 8'h00);
        chk_bit(ready, 1'b0);
        chk_bit(ready_std, 1'b1);
        // temperature channel: early conversion, then the acquisition wait
        bus_wr(vtc_pkg::CTRL_ADDR, 8'h20);
        @(posedge sys_clk_in);
        sel <= 1'b1;
        #1;
        chk_bit(route, 1'b1);
        chk_bit(acq, 1'b0);
        conv_pulse();
        chk_bit(irq, 1'b1);
        n = 0;
        while (acq !== 1'b1) begin
            if (n > 400) begin
                num_errors++;
                conclude();
            end
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        chk_bit(n >= WAITUS * USC, 1'b1);
        bus_rd(vtc_pkg::STATUS_ADDR, d);
        chk_reg(d, 8'h06);
        // a conversion after the wait restarts it and raises no early flag
        conv_pulse();
        @(posedge sys_clk_in);
        #1;
        chk_bit(acq, 1'b0);
        bus_rd(vtc_pkg::STATUS_ADDR, d);
        chk_reg(d, 8'h00);
        @(posedge sys_clk_in);
        sel <= 1'b0;
        #1;
        chk_bit(route, 1'b0);
        // reset in mid-run clears every writable field
        bus_wr(vtc_pkg::CTRL_ADDR, 8'hBF);
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        #1;
        chk_bit(ten, 1'b0);
        chk_bit(irq, 1'b0);
        bus_rd(vtc_pkg::CTRL_ADDR, d);
        chk_reg(d, 8'h00);
        bus_rd(vtc_pkg::MASK_ADDR, d);
        chk_reg(d, 8'h00);
        conclude();
    end
endmodule // vtc_top_test
